//--- rtl/see_dev.sv
// Overview of operation
// - Write control byte acknowledged on ninth clock
// - Byte after control byte loads address pointer
// - Stop after data starts write; busy, no acks
// - Protected writes acknowledged, memory untouched, full cycle
// - Protect input high guards whole array
// - Up to sixteen bytes buffered, committed at Stop
// - Write data increments only low pointer nibble
// - Excess page bytes wrap, overwriting earlier ones
// - Master avoids page writes crossing page boundary
// - Busy device ignores polls; acks once done
// - Read control byte selects the read forms
// - Current read returns byte at last address+1
// - Master nack then Stop ends device transmission
// - Repeated start aborts write, keeps new pointer
// - After random read pointer follows byte read
// - Master ack fetches next byte, incremented address
// - Read pointer wraps from top to zero
// - Respond only to code 1010 and chip select
// - On master nack, release data line high
module see_dev
    import see_pkg::*;
#(
    parameter int unsigned WC_CYC = TWC_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic [2:0] chip_select_inputs_in,
    input  wire logic       wp_in,
    see_link_if.device      link,
    output logic            busy_out
);

    // ************************************************************
    // Types and state
    // ************************************************************
    localparam int unsigned BW = $clog2(WC_CYC);

    typedef enum logic [2:0] {
        D_IDLE,
        D_CTRL,
        D_ADDR,
        D_WDATA,
        D_ACK,
        D_TX,
        D_MACK
    } see_dst_t;

    typedef struct packed {
        logic            scl_m;
        logic            scl_s;
        logic            scl_p;
        logic            sda_m;
        logic            sda_s;
        logic            sda_p;
        logic            wp_m;
        logic            wp_s;
        logic [2:0]      cs_m;
        logic [2:0]      cs_s;
        see_dst_t        st;
        see_dst_t        nxt;
        logic [7:0]      sh;
        logic [3:0]      cnt;
        logic [7:0]      ptr;
        logic            mack;
        logic [15:0]     vld;
        logic [BW-1:0]   bcnt;
        logic            busy;
        logic            sda_oe;
    } see_dev_t;

    see_dev_t r;
    see_dev_t n;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pbuf [PAGE_BYTES];
    logic [7:0] mem_q;
    logic       buf_we;
    logic       commit;
    logic       start_c;
    logic       stop_c;
    logic       rise_c;
    logic       fall_c;

    // ************************************************************
    // Line events
    // ************************************************************
    // Edges are taken from the second and third stages only
    assign start_c = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    assign stop_c  = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    assign rise_c  = r.scl_s & ~r.scl_p;
    assign fall_c  = ~r.scl_s & r.scl_p;
    assign mem_q   = mem[r.ptr];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n         = r;
        buf_we    = 1'b0;
        commit    = 1'b0;
        n.scl_m   = link.scl;
        n.scl_s   = r.scl_m;
        n.scl_p   = r.scl_s;
        n.sda_m   = link.sda;
        n.sda_s   = r.sda_m;
        n.sda_p   = r.sda_s;
        n.wp_m    = wp_in;
        n.wp_s    = r.wp_m;
        n.cs_m    = chip_select_inputs_in;
        n.cs_s    = r.cs_m;

        // Write cycle timer; acks are held off until it expires
        if (r.busy) begin
            if (r.bcnt == '0) begin
                n.busy = 1'b0;
            end else begin
                n.bcnt = r.bcnt - BW'(1);
            end
        end

        if (start_c) begin
            // A repeated start drops buffered data, pointer stays
            n.st     = D_CTRL;
            n.cnt    = '0;
            n.vld    = '0;
            n.sda_oe = 1'b0;
        end else if (stop_c) begin
            if (r.st == D_WDATA && r.vld != '0) begin
                commit = ~r.wp_s;
                n.busy = 1'b1;
                n.bcnt = BW'(WC_CYC - 1);
            end
            n.st     = D_IDLE;
            n.vld    = '0;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                D_IDLE: begin
                    n.st = D_IDLE;
                end
                D_CTRL, D_ADDR, D_WDATA: begin
                    if (rise_c && r.cnt != BYTE_BITS) begin
                        n.sh  = {r.sh[6:0], r.sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (fall_c && r.cnt == BYTE_BITS) begin
                        n.sda_oe = 1'b1;
                        n.st     = D_ACK;
                        n.nxt    = D_WDATA;
                        if (r.st == D_CTRL) begin
                            // Foreign or busy selects drop back idle
                            if (r.sh[CTL_CODE_HI:CTL_CODE_LO] != DEV_CODE
                                || r.sh[CTL_CS_HI:CTL_CS_LO] != r.cs_s
                                || r.busy) begin
                                n.sda_oe = 1'b0;
                                n.st     = D_IDLE;
                            end else if (r.sh[CTL_RW]) begin
                                n.nxt = D_TX;
                            end else begin
                                n.nxt = D_ADDR;
                            end
                        end else if (r.st == D_ADDR) begin
                            n.ptr = r.sh;
                        end else begin
                            // Page slot chosen by the low nibble only
                            buf_we              = 1'b1;
                            n.vld[r.ptr[3:0]]   = 1'b1;
                            n.ptr[3:0] = r.ptr[3:0] + 4'h1;
                        end
                    end
                end
                D_ACK: begin
                    if (fall_c) begin
                        n.sda_oe = 1'b0;
                        n.cnt    = '0;
                        n.st     = r.nxt;
                        if (r.nxt == D_TX) begin
                            n.sh     = mem_q;
                            n.ptr    = r.ptr + 8'h01;
                            n.sda_oe = ~mem_q[7];
                        end
                    end
                end
                D_TX: begin
                    if (rise_c) begin
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (fall_c) begin
                        if (r.cnt == BYTE_BITS) begin
                            n.sda_oe = 1'b0;
                            n.st     = D_MACK;
                        end else begin
                            n.sh     = {r.sh[6:0], 1'b0};
                            n.sda_oe = ~r.sh[6];
                        end
                    end
                end
                D_MACK: begin
                    if (rise_c) begin
                        n.mack = ~r.sda_s;
                    end
                    if (fall_c) begin
                        n.cnt = '0;
                        if (r.mack) begin
                            n.sh     = mem_q;
                            n.ptr    = r.ptr + 8'h01;
                            n.sda_oe = ~mem_q[7];
                            n.st     = D_TX;
                        end else begin
                            n.sda_oe = 1'b0;
                            n.st     = D_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= n;
        end
    end

    // ************************************************************
    // Page buffer and array
    // ************************************************************
    // Arrays carry no reset; contents are undefined until written
    always_ff @(posedge clk_in) begin
        if (ce_in && !rst_in && buf_we) begin
            pbuf[r.ptr[3:0]] <= r.sh;
        end
    end

    // Valid buffered bytes land in one cycle as the busy interval opens
    always_ff @(posedge clk_in) begin
        if (ce_in && !rst_in && commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (r.vld[i]) begin
                    mem[{r.ptr[7:4], 4'(i)}] <= pbuf[i];
                end
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.d_sda_out = 1'b0;       // Open drain: only pulls low
    assign link.d_sda_oe  = r.sda_oe;
    assign busy_out       = r.busy;

endmodule

//--- rtl/see_pkg.sv
package see_pkg;

    // ************************************************************
    // Clock and link timing
    // ************************************************************
    localparam int unsigned CLK_KHZ      = 25000;
    localparam int unsigned SCL_KHZ      = 400;
    // Round the half period up so the link never runs above SCL_KHZ
    localparam int unsigned SCL_HALF_CYC =
        (CLK_KHZ + 2 * SCL_KHZ - 1) / (2 * SCL_KHZ);
    // Self-timed write cycle, in microseconds and in clock cycles
    localparam int unsigned TWC_US       = 5000;
    localparam int unsigned TWC_CYC      = TWC_US * CLK_KHZ / 1000;

    // ************************************************************
    // Control byte layout and memory geometry
    // ************************************************************
    localparam logic [3:0]  DEV_CODE     = 4'ha;
    localparam int unsigned CTL_CODE_HI  = 7;
    localparam int unsigned CTL_CODE_LO  = 4;
    localparam int unsigned CTL_CS_HI    = 3;
    localparam int unsigned CTL_CS_LO    = 1;
    localparam int unsigned CTL_RW       = 0;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam int unsigned MEM_BYTES    = 256;
    localparam int unsigned PAGE_BYTES   = 16;

    // ************************************************************
    // Master byte-level commands
    // ************************************************************
    typedef enum logic [1:0] {
        SEE_OP_START,
        SEE_OP_STOP,
        SEE_OP_WRITE,
        SEE_OP_READ
    } see_op_t;

endpackage

//--- rtl/see_link_if.sv
// ****************************************************************
// Two-wire link: clock from the master, open-drain data line
// ****************************************************************
interface see_link_if;
    logic scl;
    logic m_sda_out;
    logic m_sda_oe;
    logic d_sda_out;
    logic d_sda_oe;
    logic sda;

    // Wired-AND with a pull-up: any enabled low driver wins
    assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

    modport master (
        output scl,
        output m_sda_out,
        output m_sda_oe,
        input  sda
    );

    modport device (
        input  scl,
        input  sda,
        output d_sda_out,
        output d_sda_oe
    );
endinterface

//--- rtl/see_mst.sv
module see_mst
    import see_pkg::*;
#(
    parameter int unsigned HALF = SCL_HALF_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       cmd_valid_in,
    input  see_op_t         cmd_op_in,
    input  wire logic [7:0] cmd_wdata_in,
    input  wire logic       cmd_ack_in,
    output logic            cmd_ready_out,
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_data_out,
    output logic            rsp_ack_out,
    see_link_if.master      link
);

    // ************************************************************
    // Types and state
    // ************************************************************
    localparam int unsigned DW = $clog2(HALF);

    typedef enum logic [1:0] {
        M_IDLE,
        M_START,
        M_STOP,
        M_BYTE
    } see_mst_t;

    typedef struct packed {
        logic          sda_m;
        logic          sda_s;
        see_mst_t      st;
        logic          rd;
        logic          mack;
        logic [1:0]    tick;
        logic [3:0]    bitn;
        logic [DW-1:0] div;
        logic [7:0]    sh;
        logic          scl;
        logic          sda_oe;
        logic          ready;
        logic          rsp_v;
        logic          rack;
    } see_mreg_t;

    see_mreg_t  r;
    see_mreg_t  n;
    logic       go;
    logic [1:0] tk;

    // ************************************************************
    // Tick sequencer: each tick lasts HALF clock cycles
    // ************************************************************
    always_comb begin
        n       = r;
        go      = 1'b0;
        tk      = r.tick;
        n.sda_m = link.sda;
        n.sda_s = r.sda_m;
        n.rsp_v = 1'b0;
        if (r.st == M_IDLE) begin
            n.ready = 1'b1;
            if (cmd_valid_in && r.ready) begin
                n.ready = 1'b0;
                n.div   = DW'(HALF - 1);
                n.bitn  = '0;
                go      = 1'b1;
                tk      = 2'h0;
                n.rd    = (cmd_op_in == SEE_OP_READ);
                n.mack  = cmd_ack_in;
                n.sh    = cmd_wdata_in;
                unique case (cmd_op_in)
                    SEE_OP_START: n.st = M_START;
                    SEE_OP_STOP:  n.st = M_STOP;
                    SEE_OP_WRITE: n.st = M_BYTE;
                    SEE_OP_READ:  n.st = M_BYTE;
                endcase
            end
        end else if (r.div != '0) begin
            n.div = r.div - DW'(1);
        end else begin
            n.div = DW'(HALF - 1);
            if ((r.st == M_START && r.tick == 2'h3)
                || (r.st == M_STOP && r.tick == 2'h2)
                || (r.st == M_BYTE && r.tick == 2'h2
                    && r.bitn == BYTE_BITS)) begin
                n.st    = M_IDLE;
                n.rsp_v = 1'b1;
            end else if (r.st == M_BYTE && r.tick == 2'h2) begin
                go     = 1'b1;
                tk     = 2'h0;
                n.bitn = r.bitn + 4'h1;
            end else begin
                go = 1'b1;
                tk = r.tick + 2'h1;
            end
        end

        // Line actions at the opening of each tick
        if (go) begin
            n.tick = tk;
            unique case (n.st)
                M_START: begin
                    // Repeated start: release, raise, then pull low
                    if (tk == 2'h0) n.sda_oe = 1'b0;
                    if (tk == 2'h1) n.scl = 1'b1;
                    if (tk == 2'h2) n.sda_oe = 1'b1;
                    if (tk == 2'h3) n.scl = 1'b0;
                end
                M_STOP: begin
                    if (tk == 2'h0) n.sda_oe = 1'b1;
                    if (tk == 2'h1) n.scl = 1'b1;
                    if (tk == 2'h2) n.sda_oe = 1'b0;
                end
                M_BYTE: begin
                    // Next-state copies: on the taking edge the new byte,
                    // direction and ack choice are not registered yet
                    if (tk == 2'h0) begin
                        if (n.bitn != BYTE_BITS) begin
                            n.sda_oe = ~n.rd & ~n.sh[7];
                        end else begin
                            n.sda_oe = n.rd & n.mack;
                        end
                    end
                    if (tk == 2'h1) n.scl = 1'b1;
                    if (tk == 2'h2) begin
                        n.scl = 1'b0;
                        if (r.bitn != BYTE_BITS) begin
                            n.sh = {r.sh[6:0], r.rd & r.sda_s};
                        end else begin
                            // Ninth pulse: slave ack for writes
                            n.rack = r.rd ? r.mack : ~r.sda_s;
                        end
                    end
                end
                default: n.tick = r.tick;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r     <= '0;
            r.scl <= 1'b1;
        end else if (ce_in) begin
            r <= n;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.scl       = r.scl;
    assign link.m_sda_out = 1'b0;       // Open drain: only pulls low
    assign link.m_sda_oe  = r.sda_oe;
    assign cmd_ready_out  = r.ready;
    assign rsp_valid_out  = r.rsp_v;
    assign rsp_data_out   = r.sh;
    assign rsp_ack_out    = r.rack;

endmodule

//--- verification/see_props.sv
module see_props #(
    parameter int unsigned WC_CYC = 600
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic d_sda_out,
    input wire logic d_sda_oe,
    input wire logic sda,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0]  rises_r;
    logic [7:0]  since_stop_r;
    logic [31:0] busy_cnt_r;
    logic        quiet_r;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // ************************************************************
    // Helper counters
    // ************************************************************
    // Rises since start, time since stop, length of the busy spell;
    // the first two saturate so a long idle bus cannot wrap them into a match
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rises_r      <= 4'hf;
            since_stop_r <= 8'hff;
            busy_cnt_r   <= 32'h0;
            quiet_r      <= 1'b1;
        end else begin
            if (scl && $fell(sda)) begin
                rises_r <= 4'h0;
            end else if ($rose(scl) && rises_r != 4'hf) begin
                rises_r <= rises_r + 4'h1;
            end
            if (scl && $rose(sda)) begin
                since_stop_r <= 8'h00;
            end else if (since_stop_r != 8'hff) begin
                since_stop_r <= since_stop_r + 8'h01;
            end
            busy_cnt_r <= busy_out ? busy_cnt_r + 32'h1 : 32'h0;
            // Bus is quiet from a stop until the next start
            if (scl && $fell(sda)) begin
                quiet_r <= 1'b0;
            end else if (scl && $rose(sda)) begin
                quiet_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_dev_open_drain: assert property (d_sda_oe |-> !d_sda_out)
        else $error("device drives the data line high");
    a_mst_open_drain: assert property (m_sda_oe |-> !m_sda_out)
        else $error("master drives the data line high");
    a_busy_no_ack: assert property (busy_out |-> !d_sda_oe)
        else $error("device drives the line while busy");
    a_busy_length: assert property (
        $fell(busy_out) |-> busy_cnt_r == WC_CYC)
        else $error("busy interval has the wrong length");
    a_busy_after_stop: assert property (
        $rose(busy_out) |-> since_stop_r <= 8'd10)
        else $error("write cycle began without a recent stop");
    a_ctrl_no_drive: assert property (
        $rose(scl) && rises_r < 4'h8 |-> !d_sda_oe)
        else $error("device drives during the control byte");
    a_dev_change_low: assert property (
        $changed(d_sda_oe) |-> !scl && !$past(scl))
        else $error("device changed the line while clock high");
    a_quiet_after_stop: assert property (quiet_r |-> !d_sda_oe)
        else $error("device drives the line after a stop");
    a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");

    // Main scenarios seen at least once
    cover property ($rose(scl) && rises_r == 4'h8 && d_sda_oe);
    cover property ($rose(busy_out));
    cover property (scl && $rose(sda));
endmodule

//--- verification/see_bench.sv
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    errors++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end end

module see_bench
    import see_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Short write cycle keeps the run brief but outlasts the first poll
    localparam int unsigned WC = 600;

    logic       clk_in     = 1'b0;
    logic       rst_in     = 1'b1;
    logic [2:0] cs         = 3'h5;
    logic       wp         = 1'b0;
    logic       cmd_valid  = 1'b0;
    see_op_t    cmd_op     = SEE_OP_START;
    logic [7:0] cmd_wdata  = 8'h00;
    logic       cmd_ack    = 1'b0;
    logic       cmd_ready;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_ack;
    logic       busy;
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] ra;
    int         seed       = 15;
    int         errors     = 0;
    int         n_compared = 0;

    always #20 clk_in = ~clk_in;

    // ************************************************************
    // Both ends on one link
    // ************************************************************
    see_link_if see_link_if_i ();

    see_dev #(.WC_CYC(WC)) see_dev_i (
        .clk_in               (clk_in),
        .rst_in               (rst_in),
        .ce_in                (1'b1),
        .chip_select_inputs_in(cs),
        .wp_in                (wp),
        .link                 (see_link_if_i),
        .busy_out             (busy)
    );

    see_mst #(.HALF(8)) see_mst_i (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .ce_in        (1'b1),
        .cmd_valid_in (cmd_valid),
        .cmd_op_in    (cmd_op),
        .cmd_wdata_in (cmd_wdata),
        .cmd_ack_in   (cmd_ack),
        .cmd_ready_out(cmd_ready),
        .rsp_valid_out(rsp_valid),
        .rsp_data_out (rsp_data),
        .rsp_ack_out  (rsp_ack),
        .link         (see_link_if_i)
    );

    see_props #(.WC_CYC(WC)) see_props_i (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .scl      (see_link_if_i.scl),
        .m_sda_out(see_link_if_i.m_sda_out),
        .m_sda_oe (see_link_if_i.m_sda_oe),
        .d_sda_out(see_link_if_i.d_sda_out),
        .d_sda_oe (see_link_if_i.d_sda_oe),
        .sda      (see_link_if_i.sda),
        .busy_out (busy)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic test_done();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [7:0] ctl(input logic r);
        return {DEV_CODE, cs, r};
    endfunction

    // Called at a falling edge; valid holds until the taking edge
    task automatic op(input see_op_t o, input logic [7:0] d, input logic a);
        int k;
        cmd_op = o;
        cmd_wdata = d;
        cmd_ack = a;
        cmd_valid = 1'b1;
        k = 0;
        // Ready settled at a falling edge is what the next rise samples
        while (cmd_ready !== 1'b1 && k < 50) begin
            @(negedge clk_in);
            k++;
        end
        if (cmd_ready !== 1'b1) begin
            errors++;
            test_done();
        end
        @(negedge clk_in);
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 400) begin
            @(negedge clk_in);
            k++;
        end
        if (rsp_valid !== 1'b1) begin
            errors++;
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] d, input logic ea);
        op(SEE_OP_WRITE, d, 1'b0);
        `CHK("byte ack", ea, rsp_ack)
    endtask

    // Page write, then ack polling until the write cycle ends
    task automatic wpage(input logic [7:0] a, input int n, input logic prot);
        int         i;
        int         p;
        logic [7:0] d;
        wp = prot;
        op(SEE_OP_START, 8'h00, 1'b0);
        wr(ctl(1'b0), 1'b1);
        wr(a, 1'b1);
        for (i = 0; i < n; i++) begin
            d = 8'($random(seed));
            wr(d, 1'b1);
            if (!prot) begin
                mem[{a[7:4], a[3:0] + 4'(i)}] = d;
            end
        end
        op(SEE_OP_STOP, 8'h00, 1'b0);
        `CHK("busy", 1'b1, busy)
        p = 0;
        do begin
            op(SEE_OP_START, 8'h00, 1'b0);
            op(SEE_OP_WRITE, ctl(1'b0), 1'b0);
            p++;
        end while (rsp_ack !== 1'b1 && p < 20);
        op(SEE_OP_STOP, 8'h00, 1'b0);
        `CHK("poll nacks", 1'b1, p > 1)
        `CHK("poll ack", 1'b1, rsp_ack)
        if (rsp_ack !== 1'b1) begin
            test_done();
        end
        wp = 1'b0;
    endtask

    // Random read when rnd is set, else current address; nack ends it
    task automatic rd(input logic [7:0] a, input logic rnd, input int n);
        int i;
        if (rnd) begin
            op(SEE_OP_START, 8'h00, 1'b0);
            wr(ctl(1'b0), 1'b1);
            wr(a, 1'b1);
            ptr = a;
        end
        op(SEE_OP_START, 8'h00, 1'b0);
        wr(ctl(1'b1), 1'b1);
        for (i = 0; i < n; i++) begin
            op(SEE_OP_READ, 8'h00, i < n - 1);
            `CHK("read byte", mem[ptr], rsp_data)
            ptr++;
        end
        op(SEE_OP_STOP, 8'h00, 1'b0);
        `CHK("line idle", 1'b1, see_link_if_i.sda)
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        cs = 3'($random(seed));
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        // A foreign device code and a foreign chip select get no ack
        op(SEE_OP_START, 8'h00, 1'b0);
        wr({4'hb, cs, 1'b0}, 1'b0);
        op(SEE_OP_START, 8'h00, 1'b0);
        wr({DEV_CODE, ~cs, 1'b0}, 1'b0);
        op(SEE_OP_STOP, 8'h00, 1'b0);
        // Overlong write wraps inside the top page, then a full page
        wpage(8'hf5, 20, 1'b0);
        wpage(8'h00, 16, 1'b0);
        ra = {4'($random(seed)), 4'h3};
        wpage(ra, 1, 1'b0);
        wpage(8'h02, 3, 1'b1);
        // Sequential read across the top of the array
        rd(8'hf8, 1'b1, 16);
        rd(8'h00, 1'b0, 1);
        rd(8'h0a, 1'b1, 1);
        rd(8'h00, 1'b0, 1);
        rd(ra, 1'b1, 1);
        test_done();
    end
endmodule
